// File: access_fault_logger.v
// mode capture and first access violation logger with register port
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "access_fault_logger_map.vh"
module access_fault_logger #(
	parameter PC_W = 24
) (
	input  wire                   sys_clk_i,
	input  wire                   reset_n_i,
	input  wire                   mode_pin_i,
	input  wire                   stop_mode_i,
	input  wire                   viol_valid_i,
	input  wire [3:0]             viol_initiator_i,
	input  wire [3:0]             viol_target_i,
	input  wire [3:0]             viol_access_i,
	input  wire [3:0]             viol_type_i,
	input  wire [PC_W-1:0]        cpu_pc_i,
	input  wire                   cpu_user_i,
	input  wire                   cpu_x_mask_i,
	input  wire                   cpu_i_mask_i,
	input  wire [`AFL_ADDR_W-1:0] reg_addr_i,
	input  wire [7:0]             reg_wdata_i,
	input  wire                   reg_wr_i,
	input  wire                   reg_rd_i,
	output reg  [7:0]             reg_rdata_o,
	output reg                    mode_select_bit_o,
	output reg                    log_active_o,
	output reg                    irq_o
);

	////////////////////////////////////////////////////////////////////////
	// state
	reg                      mode_select_bit_r;
	reg                      mode_armed_r;
	reg  [7:0]               source_target_r;
	reg  [7:0]               access_kind_r;
	reg                      clear_half_r;
	reg  [`AFL_EV_W-1:0]     irq_status_r;
	reg  [`AFL_EV_W-1:0]     irq_mask_r;
	reg  [`AFL_EV_W-1:0]     irq_status_nxt;
	reg  [7:0]               rdata_nxt;
	wire [PC_W-1:0]          captured_program_counter;
	wire [2:0]               captured_flags;
	wire                     log_empty;
	wire                     capture;
	wire                     accepted;
	wire                     wr_high;
	wire                     wr_low;
	wire                     clear_log;
	wire                     mode_write;
	wire                     mode_change;

	////////////////////////////////////////////////////////////////////////
	// decode
	assign log_empty   = (source_target_r == `AFL_ZERO_BYTE) &&
	                     (access_kind_r == `AFL_ZERO_BYTE);
	// only cpu and converter paths are logged; stop mode shuts capture
	assign accepted    = viol_valid_i && !stop_mode_i &&
	                     (viol_initiator_i == `AFL_INIT_CPU ||
	                      viol_initiator_i == `AFL_INIT_CONV) &&
	                     (viol_type_i == `AFL_ERR_ILLEGAL ||
	                      viol_type_i == `AFL_ERR_ECC);
	assign capture     = accepted && log_empty;
	assign wr_high     = reg_wr_i && reg_addr_i == `AFL_SOURCE_TARGET;
	assign wr_low      = reg_wr_i && reg_addr_i == `AFL_ACCESS_KIND;
	// clear needs ff to the high byte followed by ff to the low byte
	assign clear_log   = wr_low && reg_wdata_i == `AFL_CLEAR_BYTE &&
	                     clear_half_r;
	assign mode_write  = reg_wr_i && reg_addr_i == `AFL_OPERATING_MODE;
	// special mode is 0; the sole legal move sets the bit to 1
	assign mode_change = mode_write && !mode_select_bit_r &&
	                     reg_wdata_i[`AFL_MODE_BIT];

	////////////////////////////////////////////////////////////////////////
	// mode bit: strap caught on first clocked edge after reset release
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_armed_r      <= 1'b0;
			mode_select_bit_r <= 1'b0;
		end else begin
			mode_armed_r <= 1'b1;
			if (!mode_armed_r) begin
				mode_select_bit_r <= mode_pin_i;
			end else if (mode_change) begin
				mode_select_bit_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error code bytes; a new capture beats a clear in the same cycle
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			source_target_r <= `AFL_ZERO_BYTE;
			access_kind_r   <= `AFL_ZERO_BYTE;
			clear_half_r    <= 1'b0;
		end else begin
			if (wr_high) begin
				clear_half_r <= (reg_wdata_i == `AFL_CLEAR_BYTE);
			end else if (reg_wr_i) begin
				clear_half_r <= 1'b0;
			end
			if (capture) begin
				source_target_r <= {viol_initiator_i,
				                    viol_target_i};
				access_kind_r   <= {viol_access_i,
				                    viol_type_i};
			end else if (clear_log) begin
				source_target_r <= `AFL_ZERO_BYTE;
				access_kind_r   <= `AFL_ZERO_BYTE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// captured pc and status, loaded with the error code only
	// contents after a clear are stale, not scrubbed, saving a clear path
	fault_capture_reg #(
		.WIDTH (PC_W)
	) u_pc_capture (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.load_i    (capture),
		.data_i    (cpu_pc_i),
		.data_o    (captured_program_counter)
	);

	fault_capture_reg #(
		.WIDTH (3)
	) u_flag_capture (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.load_i    (capture),
		.data_i    ({cpu_user_i, cpu_x_mask_i, cpu_i_mask_i}),
		.data_o    (captured_flags)
	);

	////////////////////////////////////////////////////////////////////////
	// interrupt status: set wins over write-one-to-clear
	always @* begin
		irq_status_nxt = irq_status_r;
		if (reg_wr_i && reg_addr_i == `AFL_IRQ_STATUS) begin
			irq_status_nxt = irq_status_r & ~reg_wdata_i[`AFL_EV_W-1:0];
		end
		if (capture) begin
			irq_status_nxt[`AFL_EV_LOGGED] = 1'b1;
		end
		if (accepted && !log_empty) begin
			irq_status_nxt[`AFL_EV_DROPPED] = 1'b1; // log held
		end
		if (mode_change && mode_armed_r) begin
			irq_status_nxt[`AFL_EV_MODE] = 1'b1;
		end
	end

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_status_r <= {`AFL_EV_W{1'b0}};
			irq_mask_r   <= {`AFL_EV_W{1'b0}};
		end else begin
			irq_status_r <= irq_status_nxt;
			if (reg_wr_i && reg_addr_i == `AFL_IRQ_MASK) begin
				irq_mask_r <= reg_wdata_i[`AFL_EV_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; anything unmapped reads zero
	always @* begin
		rdata_nxt = 8'h00;
		case (reg_addr_i)
			`AFL_OPERATING_MODE: rdata_nxt = {mode_select_bit_r, 7'h00};
			`AFL_SOURCE_TARGET:  rdata_nxt = source_target_r;
			`AFL_ACCESS_KIND:    rdata_nxt = access_kind_r;
			`AFL_STATUS_HIGH:    rdata_nxt = {captured_flags[2], 7'h00};
			`AFL_STATUS_LOW:     rdata_nxt = {1'b0, captured_flags[1],
			                                  1'b0, captured_flags[0],
			                                  4'h0};
			`AFL_PC_HIGH:        rdata_nxt = captured_program_counter[23:16];
			`AFL_PC_MID:         rdata_nxt = captured_program_counter[15:8];
			`AFL_PC_LOW:         rdata_nxt = captured_program_counter[7:0];
			`AFL_IRQ_STATUS:     rdata_nxt = {5'h00, irq_status_r};
			`AFL_IRQ_MASK:       rdata_nxt = {5'h00, irq_mask_r};
			default:             rdata_nxt = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o       <= 8'h00;
			mode_select_bit_o <= 1'b0;
			log_active_o      <= 1'b0;
			irq_o             <= 1'b0;
		end else begin
			reg_rdata_o       <= reg_rd_i ? rdata_nxt : 8'h00;
			mode_select_bit_o <= mode_select_bit_r;
			log_active_o      <= !log_empty;
			irq_o             <= |(irq_status_nxt & irq_mask_r);
		end
	end

endmodule

// File: access_fault_logger_map.vh
// register offsets, field positions and reset values of the fault logger
`ifndef ACCESS_FAULT_LOGGER_MAP_VH
`define ACCESS_FAULT_LOGGER_MAP_VH

`define AFL_ADDR_W           8
`define AFL_OPERATING_MODE   8'h70
`define AFL_SOURCE_TARGET    8'h80
`define AFL_ACCESS_KIND      8'h81
`define AFL_STATUS_HIGH      8'h82
`define AFL_STATUS_LOW       8'h83
`define AFL_PC_HIGH          8'h85
`define AFL_PC_MID           8'h86
`define AFL_PC_LOW           8'h87
`define AFL_IRQ_STATUS       8'h90
`define AFL_IRQ_MASK         8'h91

`define AFL_MODE_BIT         7
`define AFL_USER_BIT         7
`define AFL_XMASK_BIT        6
`define AFL_IMASK_BIT        4
`define AFL_CLEAR_BYTE       8'hff
`define AFL_ZERO_BYTE        8'h00

`define AFL_INIT_CPU         4'h1
`define AFL_INIT_CONV        4'h3
`define AFL_ERR_ILLEGAL      4'h1
`define AFL_ERR_ECC          4'h2

`define AFL_EV_LOGGED        0
`define AFL_EV_DROPPED       1
`define AFL_EV_MODE          2
`define AFL_EV_W             3

`endif

// File: afl_asserts.sv
// port-level checks of the access fault logger
`timescale 1ns/1ps
module afl_asserts #(
	parameter PC_W = 24
) (
	input wire            sys_clk_i, reset_n_i, mode_pin_i, stop_mode_i,
	input wire            viol_valid_i, cpu_user_i, cpu_x_mask_i, cpu_i_mask_i,
	input wire [3:0]      viol_initiator_i, viol_target_i,
	input wire [3:0]      viol_access_i, viol_type_i,
	input wire [PC_W-1:0] cpu_pc_i,
	input wire [7:0]      reg_addr_i, reg_wdata_i, reg_rdata_o,
	input wire            reg_wr_i, reg_rd_i,
	input wire            mode_select_bit_o, log_active_o, irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////
	// accepted cpu report with no register write racing it
	wire cpu_ok = viol_valid_i && !stop_mode_i && !reg_wr_i &&
		viol_initiator_i == 4'h1 && viol_type_i == 4'h1;
	wire ff80 = reg_wr_i && reg_addr_i == 8'h80 && reg_wdata_i == 8'hff;
	wire ff81 = reg_wr_i && reg_addr_i == 8'h81 && reg_wdata_i == 8'hff;
	////////////////////////////////////////////////////////////////////////
	// read data only stands in the cycle after a read strobe
	a_rd_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read slot");
	a_rd_reserved: assert property (reg_rd_i && reg_addr_i == 8'h84 |=>
		reg_rdata_o == 8'h00) else $error("reserved address read not zero");
	a_mode_read: assert property (reg_rd_i && reg_addr_i == 8'h70 |=>
		reg_rdata_o == {mode_select_bit_o, 7'h00})
		else $error("mode register read mismatch");
	a_mode_one_way: assert property (mode_select_bit_o |=>
		mode_select_bit_o) else $error("mode fell back to special");
	a_mode_accept: assert property (reg_wr_i && reg_addr_i == 8'h70 &&
		reg_wdata_i[7] |=> ##1 mode_select_bit_o)
		else $error("mode write to normal not taken");
	a_log_sets: assert property (cpu_ok |=> ##1 log_active_o)
		else $error("violation did not load the log");
	// two quiet cycles rule out a clear still in flight
	a_log_hold: assert property (log_active_o && !reg_wr_i &&
		!$past(reg_wr_i) |=> log_active_o) else $error("log lost its value");
	a_stop_quiet: assert property (!log_active_o && $past(stop_mode_i)
		|=> !log_active_o) else $error("log loaded while stopped");
	a_clear_pair: assert property (ff81 && $past(ff80) && !viol_valid_i
		|=> ##1 !log_active_o) else $error("log not cleared by ffff");
	c_logged: cover property (cpu_ok);
	c_cleared: cover property (ff81 && $past(ff80));
	c_mode_up: cover property ($rose(mode_select_bit_o));
endmodule
bind access_fault_logger afl_asserts #(.PC_W(PC_W)) afl_asserts_inst (.*);

// File: fault_capture_reg.v
// parameter-width capture register that loads only on a capture strobe
`timescale 1ns/1ps
module fault_capture_reg #(
	parameter WIDTH = 8
) (
	input  wire             sys_clk_i,
	input  wire             reset_n_i,
	input  wire             load_i,
	input  wire [WIDTH-1:0] data_i,
	output reg  [WIDTH-1:0] data_o
);

	// held value changes only when the log arms a new capture
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data_o <= {WIDTH{1'b0}};
		end else if (load_i) begin
			data_o <= data_i;
		end
	end

endmodule

// File: tb.sv
// self-checking bench for the access fault logger
`timescale 1ns/1ps
module tb;
	reg         sys_clk_i, reset_n_i, mode_pin_i, stop_mode_i;
	reg  [7:0]  reg_addr_i, reg_wdata_i;
	reg         reg_wr_i, reg_rd_i;
	wire        viol_valid_i, cpu_user_i, cpu_x_mask_i, cpu_i_mask_i;
	wire [3:0]  viol_initiator_i, viol_target_i, viol_access_i, viol_type_i;
	wire [23:0] cpu_pc_i;
	wire [7:0]  reg_rdata_o;
	wire        mode_select_bit_o, log_active_o, irq_o;
	wire [15:0] code;
	wire [26:0] cpu;
	reg  [3:0]  ini, acc, tp;
	integer     num_errors, n_tests, i;
	assign {viol_initiator_i, viol_target_i, viol_access_i, viol_type_i} = code;
	assign {cpu_user_i, cpu_x_mask_i, cpu_i_mask_i, cpu_pc_i} = cpu;
	access_fault_logger access_fault_logger_inst (.*);
	viol_source viol_source_inst (.sys_clk_i(sys_clk_i),
		.valid_o(viol_valid_i), .code_o(code), .cpu_o(cpu));
	////////////////////////////////////////////////////////////////////////
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge sys_clk_i);
			reg_wr_i    <= 1'b1;
			reg_addr_i  <= a;
			reg_wdata_i <= d;
			@(posedge sys_clk_i);
			reg_wr_i    <= 1'b0;
		end
	endtask
	// data stands one cycle only, so it is sampled just after that edge
	task rd(input [7:0] a, input [7:0] exp);
		begin
			@(posedge sys_clk_i);
			reg_rd_i   <= 1'b1;
			reg_addr_i <= a;
			@(posedge sys_clk_i);
			reg_rd_i   <= 1'b0;
			#1 chk(reg_rdata_o, exp);
		end
	endtask
	// both log bytes written back to back, strobe held across the pair
	task clr;
		begin
			@(posedge sys_clk_i);
			reg_wr_i    <= 1'b1;
			reg_addr_i  <= 8'h80;
			reg_wdata_i <= 8'hff;
			@(posedge sys_clk_i);
			reg_addr_i  <= 8'h81;
			@(posedge sys_clk_i);
			reg_wr_i    <= 1'b0;
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", n_tests, num_errors);
			if (num_errors == 0 && n_tests > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#160000;
		num_errors = num_errors + 1;
		print_verdict;
	end
	initial begin
		{num_errors, n_tests, reset_n_i, mode_pin_i, stop_mode_i} = 0;
		{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = 0;
		repeat (20) @(posedge sys_clk_i);
		chk({mode_select_bit_o, log_active_o, irq_o, 5'h0}, 8'h00);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		rd(8'h70, 8'h00);
		rd(8'h84, 8'h00);
		wr(8'h91, 8'h07);
		wr(8'h70, 8'h7f);
		rd(8'h70, 8'h00);
		wr(8'h70, 8'hff);
		rd(8'h70, 8'h80);
		wr(8'h70, 8'h00);
		rd(8'h70, 8'h80);
		chk({7'h00, irq_o}, 8'h01);
		rd(8'h90, 8'h04);
		wr(8'h90, 8'h04);
		rd(8'h90, 8'h00);
		chk({7'h00, irq_o}, 8'h00);
		viol_source_inst.report(16'h1241, {3'b110, 24'h123456});
		rd(8'h80, 8'h12);
		chk({7'h00, log_active_o}, 8'h01);
		rd(8'h81, 8'h41);
		rd(8'h82, 8'h80);
		rd(8'h83, 8'h40);
		rd(8'h85, 8'h12);
		wr(8'h87, 8'hff);
		rd(8'h87, 8'h56);
		viol_source_inst.report(16'h3412, {3'b001, 24'h0abcde});
		rd(8'h80, 8'h12);
		rd(8'h86, 8'h34);
		rd(8'h90, 8'h03);
		wr(8'h81, 8'hff);
		rd(8'h81, 8'h41);
		clr;
		rd(8'h80, 8'h00);
		rd(8'h81, 8'h00);
		chk({7'h00, log_active_o}, 8'h00);
		@(posedge sys_clk_i) stop_mode_i <= 1'b1;
		viol_source_inst.report(16'h1241, 27'h0);
		@(posedge sys_clk_i) stop_mode_i <= 1'b0;
		rd(8'h80, 8'h00);
		viol_source_inst.report(16'h2241, 27'h0);
		viol_source_inst.report(16'h1243, 27'h0);
		rd(8'h80, 8'h00);
		wr(8'h90, 8'hff);
		wr(8'h91, 8'h00);
		// six reports: cpu and converter initiators, targets 0 to 5, access 0 to 4, both logged error codes
		for (i = 0; i < 6; i = i + 1) begin
			ini = i[0] ? 4'h3 : 4'h1;
			acc = (i == 5) ? 4'h0 : i[3:0];
			tp  = i[0] ? 4'h2 : 4'h1;
			viol_source_inst.report({ini, i[3:0], acc, tp},
				{i[2:0], 16'h5aa5, i[7:0]});
			rd(8'h80, {ini, i[3:0]});
			rd(8'h81, {acc, tp});
			rd(8'h82, {i[2], 7'h00});
			rd(8'h83, {1'b0, i[1], 1'b0, i[0], 4'h0});
			rd(8'h87, i[7:0]);
			clr;
		end
		rd(8'h90, 8'h01);
		chk({7'h00, irq_o}, 8'h00);
		// mid-run reset with the strap high: normal mode comes from the pin
		@(posedge sys_clk_i);
		reset_n_i  <= 1'b0;
		mode_pin_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		chk({mode_select_bit_o, log_active_o, irq_o, 5'h0}, 8'h00);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		rd(8'h70, 8'h80);
		wr(8'h70, 8'h00);
		rd(8'h70, 8'h80);
		rd(8'h80, 8'h00);
		print_verdict;
	end
endmodule

// File: viol_source.sv
// behavioural cpu and converter side raising violation reports
`timescale 1ns/1ps
module viol_source (
	input  wire        sys_clk_i,
	output reg         valid_o,
	output reg  [15:0] code_o,
	output reg  [26:0] cpu_o
);
	initial begin
		valid_o = 1'b0;
		code_o  = 16'h0000;
		cpu_o   = 27'h0;
	end
	// one-cycle report; fields inverted after so stale values never help
	task report(input [15:0] code, input [26:0] cpu);
		begin
			@(posedge sys_clk_i);
			valid_o <= 1'b1;
			code_o  <= code;
			cpu_o   <= cpu;
			@(posedge sys_clk_i);
			valid_o <= 1'b0;
			code_o  <= ~code;
			cpu_o   <= ~cpu;
		end
	endtask
endmodule
